// ==== verilog/tcf_pkg.sv ====
package tcf_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned TCF_CLK_HZ = 250_000_000;
  localparam int unsigned TCF_CNT_W = 32;
  localparam int unsigned TCF_DEAD_TIME_US = 100;
  localparam real TCF_TON_S = 0.22;
  localparam real TCF_TOFF_S = 1.3;
  localparam logic [31:0] TCF_DEAD_CYC = 32'(longint'(TCF_DEAD_TIME_US) * TCF_CLK_HZ / 1_000_000);
  localparam logic [31:0] TCF_TON_CYC = 32'(longint'(TCF_TON_S * TCF_CLK_HZ));
  localparam logic [31:0] TCF_TOFF_CYC = 32'(longint'(TCF_TOFF_S * TCF_CLK_HZ));

  // ---------------------------------------------------------------
  // variants and reset values
  // ---------------------------------------------------------------
  localparam logic TCF_VAR_TACH = 1'b0;
  localparam logic TCF_VAR_ALARM = 1'b1;
  localparam logic TCF_POLE_RST = 1'b0;

  typedef enum logic [2:0] {
    TCF_ST_RUN = 3'b001,
    TCF_ST_DEAD = 3'b010,
    TCF_ST_OFF = 3'b100
  } tcf_state_t;

  typedef struct packed {
    tcf_state_t st;
    logic pole;
    logic sel;
    logic locked;
    logic [TCF_CNT_W-1:0] cnt;
    logic coil_a_on;
    logic coil_b_on;
    logic od_on;
  } tcf_regs_t;

endpackage

// ==== verilog/tcf_commutation.sv ====
// Functional notes
// - north pole: coil a released, coil b driven on.
// - south pole: coil a driven on, coil b released.
// - between thresholds the pole holds, giving hysteresis of at least 2 mT.
// - tach variant: shared output follows the pole, one level change per change.
// - alarm variant: shared output driven low while spinning normally.
// - alarm variant: output released high when pole changes become too rare.
// - locked or too slow rotor: both coil drivers turned off.
// - while locked, restart attempt after each 1.3 s off period until rotation resumes.
// - retry on/off timing keeps average drive near one seventh.
// - right after power-on the alarm output is held low.
// - no commutation within the on window after power-on releases the alarm.
// - each commutation inserts a dead time with both coil drivers off.
`timescale 1ns/100ps
`default_nettype none
module tcf_commutation import tcf_pkg::*; #(
  parameter logic VARIANT = TCF_VAR_TACH,
  parameter logic [31:0] DEAD_CYC = TCF_DEAD_CYC,
  parameter logic [31:0] TON_CYC = TCF_TON_CYC,
  parameter logic [31:0] TOFF_CYC = TCF_TOFF_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic field_south,
  input wire logic field_north,
  input wire logic coil_a_drive_in,
  output logic coil_a_drive_o,
  output logic coil_a_drive_oe,
  input wire logic coil_b_drive_in,
  output logic coil_b_drive_o,
  output logic coil_b_drive_oe,
  input wire logic status_pin_in,
  output logic status_pin_o,
  output logic status_pin_oe
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tcf_regs_t s_r;
  tcf_regs_t s_nxt;
  logic pole_chg;

  function automatic logic cnt_done(input logic [TCF_CNT_W-1:0] c, input logic [31:0] lim);
    cnt_done = (c >= lim - 32'h0000_0001);
  endfunction

  // a coil conducts only in the run state and only on its own pole side
  function automatic logic coil_drive(input tcf_state_t st, input logic sel, input logic side);
    coil_drive = (st == TCF_ST_RUN) && (sel == side);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.cnt = s_r.cnt + 32'h0000_0001;
    // hysteresis: only a crossing of either threshold moves the pole
    if (field_south) begin
      s_nxt.pole = 1'b1;
    end else if (field_north) begin
      s_nxt.pole = 1'b0;
    end
    pole_chg = (s_nxt.pole != s_r.pole);
    unique case (s_r.st)
      TCF_ST_RUN: begin
        if (pole_chg) begin
          s_nxt.st = TCF_ST_DEAD;
          s_nxt.cnt = '0;
          s_nxt.locked = 1'b0;
        end else if (cnt_done(s_r.cnt, TON_CYC)) begin
          s_nxt.st = TCF_ST_OFF;
          s_nxt.cnt = '0;
          s_nxt.locked = 1'b1;
        end
      end
      TCF_ST_DEAD: begin
        if (cnt_done(s_r.cnt, DEAD_CYC)) begin
          s_nxt.st = TCF_ST_RUN;
          s_nxt.sel = s_nxt.pole;
          s_nxt.cnt = '0;
        end
      end
      TCF_ST_OFF: begin
        if (cnt_done(s_r.cnt, TOFF_CYC)) begin
          s_nxt.st = TCF_ST_RUN;
          s_nxt.sel = s_nxt.pole;
          s_nxt.cnt = '0;
        end
      end
      default: begin
        s_nxt.st = TCF_ST_OFF;
        s_nxt.cnt = '0;
      end
    endcase
    s_nxt.coil_a_on = coil_drive(s_nxt.st, s_nxt.sel, 1'b1);
    s_nxt.coil_b_on = coil_drive(s_nxt.st, s_nxt.sel, 1'b0);
    if (VARIANT == TCF_VAR_ALARM) begin
      s_nxt.od_on = !s_nxt.locked;
    end else begin
      s_nxt.od_on = !s_nxt.pole;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{
        st: TCF_ST_RUN,
        pole: TCF_POLE_RST,
        sel: TCF_POLE_RST,
        locked: 1'b0,
        cnt: '0,
        coil_a_on: 1'b0,
        coil_b_on: 1'b0,
        od_on: 1'b1
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  assign coil_a_drive_o = 1'b0;
  assign coil_b_drive_o = 1'b0;
  assign status_pin_o = 1'b0;
  assign coil_a_drive_oe = s_r.coil_a_on;
  assign coil_b_drive_oe = s_r.coil_b_on;
  assign status_pin_oe = s_r.od_on;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence commutate_s;
    s_r.st == TCF_ST_RUN && pole_chg;
  endsequence
  sequence dead_gap_s;
    s_r.st == TCF_ST_DEAD && !coil_a_drive_oe && !coil_b_drive_oe;
  endsequence

  // ---------------------------------------------------------------
  // single-cycle sequences
  // ---------------------------------------------------------------
  sequence stall_s;
    s_r.st == TCF_ST_RUN && !pole_chg && cnt_done(s_r.cnt, TON_CYC);
  endsequence
  sequence locked_off_s;
    s_r.st == TCF_ST_OFF && s_r.locked && !coil_a_drive_oe && !coil_b_drive_oe;
  endsequence
  sequence dead_last_s;
    s_r.st == TCF_ST_DEAD && cnt_done(s_r.cnt, DEAD_CYC);
  endsequence
  sequence drive_one_s;
    s_r.st == TCF_ST_RUN && (coil_a_drive_oe != coil_b_drive_oe);
  endsequence

  never_both_on_a: assert property (!(coil_a_drive_oe && coil_b_drive_oe))
    else $error("both coil drivers on");
  dead_after_chg_a: assert property (commutate_s |=> dead_gap_s)
    else $error("no dead time after commutation");
  coil_follow_a: assert property (s_nxt.st == TCF_ST_RUN |=> coil_a_drive_oe == s_r.sel &&
                                  coil_b_drive_oe == !s_r.sel)
    else $error("coil drive does not follow selected pole");
  south_pole_a: assert property (field_south |=> s_r.pole)
    else $error("south field did not set pole");
  hold_pole_a: assert property (!field_south && !field_north |=> $stable(s_r.pole))
    else $error("pole moved between thresholds");
  lock_off_a: assert property (s_r.st == TCF_ST_OFF |-> !coil_a_drive_oe && !coil_b_drive_oe)
    else $error("coil driven while locked off");
  stall_lock_a: assert property (s_r.st == TCF_ST_RUN && !pole_chg && cnt_done(s_r.cnt, TON_CYC)
                                 |=> s_r.st == TCF_ST_OFF && s_r.locked)
    else $error("missing lock after on window");
  retry_a: assert property (s_r.st == TCF_ST_OFF && cnt_done(s_r.cnt, TOFF_CYC)
                            |=> s_r.st == TCF_ST_RUN && s_r.cnt == '0)
    else $error("retry did not start after off period");
  resume_a: assert property (commutate_s |=> !s_r.locked)
    else $error("pole change did not clear lock");
  status_out_a: assert property (VARIANT == TCF_VAR_ALARM ? status_pin_oe == !s_r.locked
                                 : status_pin_oe == !s_r.pole)
    else $error("status pin does not match variant behaviour");

  // ---------------------------------------------------------------
  // pole, window and dead-time checks
  // ---------------------------------------------------------------
  north_pole_a: assert property (field_north && !field_south |=> !s_r.pole)
    else $error("north field did not clear pole");
  stall_off_a: assert property (stall_s |=> locked_off_s)
    else $error("coils still driven after stall");
  dead_span_a: assert property (s_r.st == TCF_ST_DEAD && !cnt_done(s_r.cnt, DEAD_CYC)
                                |=> s_r.st == TCF_ST_DEAD)
    else $error("dead time cut short");
  dead_end_a: assert property (dead_last_s |=> drive_one_s)
    else $error("no single coil driven after dead time");
  off_span_a: assert property (s_r.st == TCF_ST_OFF && !cnt_done(s_r.cnt, TOFF_CYC)
                               |=> locked_off_s)
    else $error("off period cut short");
  retry_drive_a: assert property (s_r.st == TCF_ST_OFF && cnt_done(s_r.cnt, TOFF_CYC)
                                  |=> drive_one_s)
    else $error("no coil driven on retry");
  lock_keep_a: assert property (s_r.locked && s_r.st == TCF_ST_RUN && !pole_chg |=> s_r.locked)
    else $error("lock dropped without rotation");
  run_span_a: assert property (s_r.st == TCF_ST_RUN && !pole_chg && !cnt_done(s_r.cnt, TON_CYC)
                               |=> s_r.st == TCF_ST_RUN)
    else $error("run ended before on window");
  run_bound_a: assert property (s_r.st == TCF_ST_RUN |-> s_r.cnt < TON_CYC)
    else $error("on window counter overran");

  // ---------------------------------------------------------------
  // shared output checks
  // ---------------------------------------------------------------
  tach_follow_a: assert property (VARIANT == TCF_VAR_TACH && $changed(s_r.pole)
                                  |-> $changed(status_pin_oe))
    else $error("tach output missed a pole change");
  alarm_spin_a: assert property ((VARIANT == TCF_VAR_ALARM) ##0 commutate_s |=> status_pin_oe)
    else $error("alarm not low after commutation");
  alarm_stall_a: assert property ((VARIANT == TCF_VAR_ALARM) ##0 stall_s |=> !status_pin_oe)
    else $error("alarm not released after stall");

endmodule
`default_nettype wire

// ==== verification/tcf_fan_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// coils and pulled-up status line as the pins see them
module tcf_fan_model (
  input wire logic coil_a_oe,
  input wire logic coil_b_oe,
  input wire logic status_oe,
  input wire logic coil_a_lvl,
  input wire logic coil_b_lvl,
  input wire logic status_lvl,
  output logic coil_a_pin,
  output logic coil_b_pin,
  output logic status_pin
);
  // a driven pin shows the driven level; a released one floats up through its coil or pull-up
  assign coil_a_pin = coil_a_oe ? coil_a_lvl : 1'b1;
  assign coil_b_pin = coil_b_oe ? coil_b_lvl : 1'b1;
  assign status_pin = status_oe ? status_lvl : 1'b1;
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic fs = 1'b0;
  logic fn = 1'b0;
  wire logic [1:0] a_oe, b_oe, s_oe, a_o, b_o, s_o, pa, pb, ps;
  int error_cnt = 0;
  int samples_checked = 0;
  // ---------------------------------------------------------------
  // tach build (index 0) and alarm build (index 1) side by side
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : v
    tcf_commutation #(.VARIANT(1'(g)), .DEAD_CYC(32'h4), .TON_CYC(32'h28), .TOFF_CYC(32'hF0)) dut_u (
      .ref_clk(ref_clk), .rstn(rstn), .field_south(fs), .field_north(fn),
      .coil_a_drive_in(pa[g]), .coil_a_drive_o(a_o[g]), .coil_a_drive_oe(a_oe[g]),
      .coil_b_drive_in(pb[g]), .coil_b_drive_o(b_o[g]), .coil_b_drive_oe(b_oe[g]),
      .status_pin_in(ps[g]), .status_pin_o(s_o[g]), .status_pin_oe(s_oe[g]));
    tcf_fan_model fan_u (.coil_a_oe(a_oe[g]), .coil_b_oe(b_oe[g]), .status_oe(s_oe[g]),
      .coil_a_lvl(a_o[g]), .coil_b_lvl(b_o[g]), .status_lvl(s_o[g]),
      .coil_a_pin(pa[g]), .coil_b_pin(pb[g]), .status_pin(ps[g]));
  end
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // pins: coil a, coil b, tach, alarm, alarm build coil a, alarm build coil b
  task automatic step(input int n, input logic [5:0] exp);
    repeat (n) @(negedge ref_clk);
    chk({pa[0], pb[0], ps[0], ps[1], pa[1], pb[1]}, exp);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_power_on();
    step(2, 6'h22);
    $display("power-on test done");
  endtask
  // dead time is 4 cycles, on window 40, off period 240 in this build
  task automatic t_south();
    fs = 1'b1;
    step(1, 6'h3B);
    step(3, 6'h3B);
    step(1, 6'h19);
    step(3, 6'h19);
    fs = 1'b0;
    step(4, 6'h19);
    $display("south pole test done");
  endtask
  task automatic t_locked();
    step(32, 6'h19);
    step(1, 6'h3F);
    step(239, 6'h3F);
    step(1, 6'h1D);
    step(27, 6'h1D);
    fn = 1'b1;
    step(1, 6'h33);
    step(3, 6'h33);
    step(1, 6'h22);
    step(3, 6'h22);
    $display("locked rotor test done");
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    t_power_on();
    t_south();
    t_locked();
    give_verdict();
  end
  initial begin
    #10000;
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
